/* inc/rcseq_pkg.sv */
package rcseq_pkg;

  // ****************************************************************
  // register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0]  CTRL_OFS       = 8'h00;  // misc_control_one: prescale, enable, plug ie, soft reset
  localparam logic [7:0]  STAT_OFS       = 8'h04;  // sequencer state and sources
  localparam logic [7:0]  VEC_OFS        = 8'h08;  // reset vector address pair
  localparam logic [7:0]  OPT_OFS        = 8'h0c;  // option: power switch pin as plain i/o

  // ****************************************************************
  // field positions of the control and option words
  // ****************************************************************
  localparam int          CTRL_CP_LSB    = 0;      // cpu_clock_prescale[1:0]
  localparam int          CTRL_PRESCALE_ENABLE_BIT  = 2;      // prescale_enable
  localparam int          CTRL_PLUG_INTERRUPT_ENABLE_BIT = 3;      // plug_interrupt_enable
  localparam int          CTRL_SWRST_BIT = 4;      // write one: software reset pulse
  localparam int          OPT_PF4IO_BIT  = 0;      // port_f_line_four as plain i/o

  // ****************************************************************
  // reset values and fixed numbers
  // ****************************************************************
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] VECTOR_LO      = 16'hfffe;
  localparam logic [15:0] VECTOR_HI      = 16'hffff;
  localparam int          DELAY_SA_CYC   = 512;    // stand-alone delay
  localparam int          DELAY_USB_CYC  = 256;    // usb delay after lock
  localparam int          FETCH_CYC      = 2;      // vector fetch
  localparam int          CLK_NS         = 100;    // reference clock period
  localparam int          LOW_OUT_NS     = 1000;   // least pin low output time
  localparam int          LOW_OUT_CYC    = (LOW_OUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int          GLITCH_NS      = 400;    // supply glitch filter time
  localparam int          GLITCH_CYC     = (GLITCH_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {ST_ACTIVE, ST_WAIT_LOCK, ST_DELAY, ST_FETCH, ST_RUN} rcseq_state_t;

  // ahb address phase bundle
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } rcseq_aphase_t;

  // whole state of the sequencer
  typedef struct packed {
    rcseq_state_t  state;
    logic [9:0]    cnt;        // delay / stretch / fetch counter
    logic [3:0]    glitch;     // supply filter counter
    logic          lv;         // filtered low-supply flag
    logic          ext_seen;   // external pulse latched
    logic [1:0]    cp;         // cpu_clock_prescale
    logic          prescale_enable;       // prescale_enable
    logic          plug_interrupt_enable;      // plug_interrupt_enable
    logic          pf4_io;     // port_f_line_four as i/o
    logic          usb_mode;   // mode taken at reset
    logic          swrst;      // software reset request
    logic [2:0]    div;        // cpu clock divider count
    logic          fclk;       // cpu clock level
    logic          ap_valid;
    rcseq_aphase_t ap;
    logic [31:0]   rdata;
  } rcseq_regs_t;

endpackage : rcseq_pkg

/* rtl/rcseq_top.sv */
`timescale 1ns/1ps
`default_nettype none

module rcseq_top
  import rcseq_pkg::*;
#(
  parameter int DELAY_SA  = DELAY_SA_CYC,           // stand-alone delay cycles
  parameter int DELAY_USB = DELAY_USB_CYC           // usb delay cycles
)(
  input  wire logic        I_REF_CLK,               // reference clock
  input  wire logic        I_NRST,                  // synchronous reset, low
  input  wire logic        I_HSEL,                  // ahb slave select
  input  wire logic [31:0] I_HADDR,                 // ahb address
  input  wire logic [1:0]  I_HTRANS,                // ahb transfer type
  input  wire logic        I_HWRITE,                // ahb write
  input  wire logic [2:0]  I_HSIZE,                 // ahb size
  input  wire logic        I_HREADY,                // ahb bus ready
  input  wire logic [31:0] I_HWDATA,                // ahb write data
  output logic [31:0]      O_HRDATA,                // ahb read data
  output logic             O_HREADYOUT,             // ahb slave ready
  output logic             O_HRESP,                 // ahb response
  input  wire logic        I_RESET_PIN,             // reset pin level
  output logic             O_RESET_PIN_OE_N,        // low: pin pulled low
  input  wire logic        I_SUPPLY_LOW_RISE,       // supply below upper threshold
  input  wire logic        I_SUPPLY_LOW_FALL,       // supply below lower threshold
  input  wire logic        I_WDG_UNDERFLOW,         // watchdog underflow pulse
  input  wire logic        I_USB_SUPPLY,            // usb supply present
  input  wire logic        I_PLL_LOCK,              // pll lock
  output logic             O_PLL_EN,                // pll running
  output logic             O_USB_CLK_EN,            // usb clock enabled
  output logic             O_OSC_48M_SEL,           // oscillator from pll
  output logic             O_FCPU,                  // cpu clock level
  output logic             O_CORE_RESET_N,          // core held in reset, low
  output logic             O_VECTOR_FETCH,          // vector fetch phase
  output logic [15:0]      O_VECTOR_ADDR,           // vector byte address
  output logic             O_PLUG_IE,               // plug interrupt enable
  output logic             O_USB_PSW_OUT,           // usb_power_switch_pin level
  output logic             O_USB_PSW_OE_N,          // low: switch pin driven
  output logic             O_PF4_IO_SEL             // switch pin as plain i/o
);

  // ****************************************************************
  // state and asynchronous catch
  // ****************************************************************
  rcseq_regs_t r;                                   // registered state
  rcseq_regs_t next_r;                              // next state
  logic        ext_async;                           // pin low caught without clock
  logic        ext_sync1;                           // first sync stage
  logic        ext_sync2;                           // second sync stage
  logic        src_ext;                             // external source level
  logic        src_any;                             // any source active
  logic        wr_hit;                              // write data phase
  logic        low_raw;                             // raw supply-low with hysteresis
  logic [9:0]  delay_len;                           // mode delay length
  logic        ext_clr;                             // clears the pin catch

  // ****************************************************************
  // phase decode
  // ****************************************************************
  // phases in which the device itself pulls the reset pin low
  function automatic logic pin_pulled(input rcseq_state_t st);
  begin
    pin_pulled = (st == ST_ACTIVE)
                 || (st == ST_WAIT_LOCK)
                 || (st == ST_DELAY);
  end
  endfunction : pin_pulled

  // catch is held clear while the device pulls the pin itself, so our
  // own pull-down never reads back as a fresh external pulse, and under
  // the synchronous reset, so the catch never starts unknown
  assign ext_clr = ext_sync2 | ~I_NRST | pin_pulled(r.state);

  // pin edge latches even with the clock stopped; cleared when synced
  always_ff @(negedge I_RESET_PIN or posedge ext_clr)
  begin
    if (ext_clr)
      ext_async <= 1'b0;
    else
      ext_async <= 1'b1;
  end

  // two-stage synchroniser of the caught pulse
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST)
    begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
    end
    else
    begin
      ext_sync1 <= ext_async;
      ext_sync2 <= ext_sync1;
    end
  end

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  // hysteresis: lower threshold once running, upper while held
  assign low_raw   = r.lv ? I_SUPPLY_LOW_RISE : I_SUPPLY_LOW_FALL;
  assign src_ext   = ext_sync2 | r.ext_seen;
  assign src_any   = src_ext | r.lv | I_WDG_UNDERFLOW | r.swrst;
  assign wr_hit    = r.ap_valid & r.ap.write;
  assign delay_len = r.usb_mode ? 10'(DELAY_USB - 1) : 10'(DELAY_SA - 1);

  // ****************************************************************
  // next state
  // ****************************************************************
  // reset phases at a glance:
  //   active    - pin pulled low, counter runs up to the least low time
  //               so a short pulse or a watchdog kick is stretched
  //   wait lock - usb mode only: pin still low, counter held at zero
  //               until the pll reports lock
  //   delay     - pin still low, counter runs the mode's delay length
  //   fetch     - pin released, two cycles of vector address output
  //   run       - core released, sources watched for the next reset
  // hazards and limits:
  //   - the supply mode is taken once, on leaving the active phase, so
  //     a supply change in mid-delay only counts at the next reset
  //   - any source seen during wait lock or delay goes back to active
  //     and the whole delay is counted again once it has gone
  //   - an external pulse that arrives while the device already pulls
  //     the pin is not seen: the device is in reset anyway
  //   - a pulse held longer than the least low time gets no stretch of
  //     its own; the pin level itself is not read back by the sequencer
  //   - the supply flag keeps the active phase open for as long as it
  //     stands, so a slow supply ramp simply lengthens the active phase
  //   - the software reset bit is a one-cycle strobe, never stored
  //   - the cpu clock divider keeps running through reset, so the
  //     peripherals see a steady clock across every phase
  // counter use:
  //   the one counter serves stretch, delay and fetch in turn and is
  //   cleared on every phase change except fetch to run, so no count leaks between phases
  // bus side:
  //   zero wait states; the address phase is captured here and the
  //   write lands in the following data phase, the read data is
  //   prepared from the address phase so it stands in the data phase
  always_comb
  begin
    next_r          = r;
    next_r.swrst    = 1'b0;
    next_r.ext_seen = 1'b0;
    // supply filter: level must persist before it counts
    if (low_raw != r.lv)
    begin
      if (r.glitch == 4'(GLITCH_CYC - 1))
      begin
        next_r.lv     = low_raw;
        next_r.glitch = 4'h0;
      end
      else
        next_r.glitch = r.glitch + 4'h1;
    end
    else
      next_r.glitch = 4'h0;
    // sequencer
    unique case (r.state)
      ST_RUN:
      begin
        if (src_any)
        begin
          next_r.state    = ST_ACTIVE;
          next_r.cnt      = 10'h000;
          next_r.ext_seen = src_ext;
        end
      end
      ST_ACTIVE:
      begin
        // least low time for pulse or watchdog, longer pulse no stretch
        next_r.ext_seen = 1'b0;
        if (r.cnt != 10'(LOW_OUT_CYC))
          next_r.cnt = r.cnt + 10'h001;
        else if (!r.lv && !ext_sync2)
        begin
          next_r.usb_mode = I_USB_SUPPLY;
          next_r.cnt      = 10'h000;
          next_r.state    = I_USB_SUPPLY ? ST_WAIT_LOCK : ST_DELAY;
        end
      end
      ST_WAIT_LOCK:
      begin
        if (src_any)
          next_r.state = ST_ACTIVE;
        else if (I_PLL_LOCK)
          next_r.state = ST_DELAY;
        next_r.cnt = 10'h000;
      end
      ST_DELAY:
      begin
        if (src_any)
        begin
          next_r.state = ST_ACTIVE;
          next_r.cnt   = 10'h000;
        end
        else if (r.cnt == delay_len)
        begin
          next_r.state = ST_FETCH;
          next_r.cnt   = 10'h000;
        end
        else
          next_r.cnt = r.cnt + 10'h001;
      end
      ST_FETCH:
      begin
        if (r.cnt == 10'(FETCH_CYC - 1))
          next_r.state = ST_RUN;
        else
          next_r.cnt = r.cnt + 10'h001;
      end
    endcase
    // cpu clock: toggles every cp+2 reference cycles, fref/(2*(cp+2)) from 10 MHz; prescale_enable has no effect
    if (r.div == 3'h0)
    begin
      next_r.fclk = ~r.fclk;
      next_r.div  = 3'(({1'b0, r.cp} + 3'h1) >> (r.prescale_enable ? 0 : 0));
    end
    else
      next_r.div = r.div - 3'h1;
    // bus address phase capture
    next_r.ap_valid  = I_HSEL & I_HREADY & I_HTRANS[1];
    next_r.ap.sel    = I_HSEL;
    next_r.ap.write  = I_HWRITE;
    next_r.ap.addr   = I_HADDR[7:0];
    // register writes
    if (wr_hit && r.ap.addr == CTRL_OFS)
    begin
      next_r.cp    = I_HWDATA[CTRL_CP_LSB +: 2];
      next_r.prescale_enable  = I_HWDATA[CTRL_PRESCALE_ENABLE_BIT];
      next_r.plug_interrupt_enable = I_HWDATA[CTRL_PLUG_INTERRUPT_ENABLE_BIT];
      next_r.swrst = I_HWDATA[CTRL_SWRST_BIT];
    end
    if (wr_hit && r.ap.addr == OPT_OFS)
      next_r.pf4_io = I_HWDATA[OPT_PF4IO_BIT];
    // read data
    next_r.rdata = 32'h0;
    if (I_HSEL & I_HREADY & I_HTRANS[1] & ~I_HWRITE)
    begin
      unique case (I_HADDR[7:0])
        CTRL_OFS: next_r.rdata = {27'h0, 1'b0, r.plug_interrupt_enable, r.prescale_enable, r.cp};
        STAT_OFS: next_r.rdata = {24'h0, r.lv, r.usb_mode, I_PLL_LOCK, src_ext, 1'b0, r.state};
        VEC_OFS:  next_r.rdata = {VECTOR_HI, VECTOR_LO};
        OPT_OFS:  next_r.rdata = {31'h0, r.pf4_io};
        default:  next_r.rdata = 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST)
    begin
      r          <= '0;
      r.state    <= ST_ACTIVE;
      r.cp       <= CTRL_RESET[1:0];
    end
    else
      r <= next_r;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign O_HRDATA         = r.rdata;
  assign O_HREADYOUT      = 1'b1;
  assign O_HRESP          = 1'b0;
  // pin pulled low in active, wait lock and delay phases
  assign O_RESET_PIN_OE_N = !pin_pulled(r.state);
  assign O_CORE_RESET_N   = (r.state == ST_RUN);
  assign O_VECTOR_FETCH   = (r.state == ST_FETCH);
  assign O_VECTOR_ADDR    = (r.cnt[0]) ? VECTOR_HI : VECTOR_LO;
  assign O_PLL_EN         = r.usb_mode;
  assign O_USB_CLK_EN     = r.usb_mode;
  assign O_OSC_48M_SEL    = r.usb_mode;
  assign O_FCPU           = r.fclk;
  assign O_PLUG_IE        = r.plug_interrupt_enable;
  assign O_USB_PSW_OUT    = 1'b0;
  assign O_USB_PSW_OE_N   = !(r.usb_mode && !r.pf4_io);
  assign O_PF4_IO_SEL     = r.pf4_io;

endmodule : rcseq_top

`default_nettype wire

/* test/rcseq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// reset sequencer port checker
// ****************************************************************
module rcseq_properties
#(
  parameter int DELAY_SA  = 512,   // stand-alone delay cycles
  parameter int DELAY_USB = 256    // usb delay cycles
)(
  input wire logic        I_REF_CLK,
  input wire logic        I_NRST,
  input wire logic        I_RESET_PIN,
  input wire logic        I_WDG_UNDERFLOW,
  input wire logic        I_PLL_LOCK,
  input wire logic        O_RESET_PIN_OE_N,
  input wire logic        O_PLL_EN,
  input wire logic        O_USB_CLK_EN,
  input wire logic        O_OSC_48M_SEL,
  input wire logic        O_CORE_RESET_N,
  input wire logic        O_VECTOR_FETCH,
  input wire logic [15:0] O_VECTOR_ADDR,
  input wire logic        O_USB_PSW_OUT,
  input wire logic        O_USB_PSW_OE_N,
  input wire logic        O_PF4_IO_SEL
);
  logic [9:0] low_cnt;   // cycles pin held low before fetch
  logic [9:0] lock_cnt;  // cycles held low with pll locked
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  // count held-low run, saturating
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST || O_RESET_PIN_OE_N || O_VECTOR_FETCH) low_cnt <= '0;
    else if (low_cnt != 10'h3ff) low_cnt <= low_cnt + 10'h1;
    if (!I_NRST || O_RESET_PIN_OE_N || O_VECTOR_FETCH || !I_PLL_LOCK) lock_cnt <= '0;
    else if (lock_cnt != 10'h3ff) lock_cnt <= lock_cnt + 10'h1;
  end
  a_sa_delay_len: assert property ($rose(O_VECTOR_FETCH) && !O_PLL_EN |-> low_cnt >= DELAY_SA)
    else $error("stand-alone delay too short or pin released");
  a_usb_delay_len: assert property ($rose(O_VECTOR_FETCH) && O_PLL_EN |-> lock_cnt >= DELAY_USB)
    else $error("usb delay not counted from lock");
  a_fetch_two: assert property ($rose(O_VECTOR_FETCH) |-> O_VECTOR_FETCH ##1 O_VECTOR_FETCH ##1 !O_VECTOR_FETCH)
    else $error("vector fetch not two cycles");
  a_vector_pair: assert property ($rose(O_VECTOR_FETCH) |-> O_VECTOR_ADDR == 16'hfffe ##1 O_VECTOR_ADDR == 16'hffff)
    else $error("vector address pair wrong");
  a_run_after_fetch: assert property ($rose(O_CORE_RESET_N) |-> $past(O_VECTOR_FETCH))
    else $error("core released without vector fetch");
  a_clock_mode: assert property (O_USB_CLK_EN == O_PLL_EN && O_OSC_48M_SEL == O_PLL_EN)
    else $error("clock enables disagree with mode");
  a_switch_low: assert property (O_PLL_EN && !O_PF4_IO_SEL |-> !O_USB_PSW_OE_N && !O_USB_PSW_OUT)
    else $error("power switch not driven low in usb mode");
  a_switch_float: assert property (!O_PLL_EN |-> O_USB_PSW_OE_N)
    else $error("power switch driven in stand-alone mode");
  a_ext_stretch: assert property ($fell(I_RESET_PIN) && O_CORE_RESET_N |-> ##[1:3] (!O_RESET_PIN_OE_N) [*8])
    else $error("external pulse not stretched");
  a_wdg_reset: assert property ($rose(I_WDG_UNDERFLOW) && O_CORE_RESET_N |-> ##[1:3] (!O_CORE_RESET_N && !O_RESET_PIN_OE_N))
    else $error("watchdog underflow did not reset");
  c_usb_boot: cover property ($rose(O_VECTOR_FETCH) && O_PLL_EN);
  c_sa_boot: cover property ($rose(O_VECTOR_FETCH) && !O_PLL_EN);
  c_ext_pulse: cover property ($fell(I_RESET_PIN) && O_CORE_RESET_N);
endmodule : rcseq_properties
bind rcseq_top rcseq_properties #(.DELAY_SA(DELAY_SA), .DELAY_USB(DELAY_USB)) u_props (
  .I_REF_CLK, .I_NRST, .I_RESET_PIN, .I_WDG_UNDERFLOW, .I_PLL_LOCK, .O_RESET_PIN_OE_N,
  .O_PLL_EN, .O_USB_CLK_EN, .O_OSC_48M_SEL, .O_CORE_RESET_N, .O_VECTOR_FETCH,
  .O_VECTOR_ADDR, .O_USB_PSW_OUT, .O_USB_PSW_OE_N, .O_PF4_IO_SEL);
`default_nettype wire

/* test/rcseq_board.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// board side of the reset pin
// ****************************************************************
module rcseq_board (
  input  wire logic i_dev_oe_n,  // device pulls pin when low
  input  wire logic i_pull,      // board circuitry pulls pin
  output logic      o_pin        // resolved pin level
);
  // open drain with weak pull-up: any party pulling wins
  assign o_pin = (i_dev_oe_n === 1'b0 || i_pull === 1'b1) ? 1'b0 : 1'b1;
endmodule : rcseq_board
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// reset sequencer bench
// ****************************************************************
module testbench;
  import rcseq_pkg::*;
  localparam int SA  = 16;  // shortened stand-alone delay
  localparam int USB = 8;   // shortened usb delay
  logic        clk, nrst, hsel, hwrite, usb, lock, slr, slf, wdg, pull, pin;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hready, hresp, oe_n, pll_en, uclk, sel48, fcpu, core_n;
  logic        fetch, plug, psw, psw_oe_n, pf4;
  logic [15:0] vaddr;
  int          mismatches, compares, n;
  rcseq_top #(.DELAY_SA(SA), .DELAY_USB(USB)) dut (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HREADY(hready),
    .I_HWDATA(hwdata), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_RESET_PIN(pin), .O_RESET_PIN_OE_N(oe_n), .I_SUPPLY_LOW_RISE(slr),
    .I_SUPPLY_LOW_FALL(slf), .I_WDG_UNDERFLOW(wdg), .I_USB_SUPPLY(usb),
    .I_PLL_LOCK(lock), .O_PLL_EN(pll_en), .O_USB_CLK_EN(uclk), .O_OSC_48M_SEL(sel48),
    .O_FCPU(fcpu), .O_CORE_RESET_N(core_n), .O_VECTOR_FETCH(fetch),
    .O_VECTOR_ADDR(vaddr), .O_PLUG_IE(plug), .O_USB_PSW_OUT(psw),
    .O_USB_PSW_OE_N(psw_oe_n), .O_PF4_IO_SEL(pf4));
  rcseq_board board (.i_dev_oe_n(oe_n), .i_pull(pull), .o_pin(pin));
  always #50 clk = ~clk;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin mismatches++; $display("ERROR %s expected %h seen %h", nm, e, s); end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // one ahb single word transfer
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= a; hsize <= 3'b010;
    k = 0;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
    if (k >= 50) mismatches++;
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
    k = 0;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
    if (k >= 50) mismatches++;
    r = hrdata;
  endtask : bus
  // wait for fetch, then check fetch and release
  task automatic t_seq(output int c);
    int b;
    c = 0; b = 0;
    while (fetch !== 1'b1 && c < 3000) begin if (oe_n !== 1'b0) b++; @(posedge clk); c++; end
    chk("pin_held", b, 0);
    chk("vec_lo", {fetch, vaddr}, 17'h1fffe);
    @(posedge clk);
    chk("vec_hi", {fetch, vaddr}, 17'h1ffff);
    @(posedge clk);
    chk("run", {fetch, core_n}, 2'b01);
  endtask : t_seq
  task automatic t_regs;
    int h, l, k;
    bus(0, CTRL_OFS, 0); chk("ctrl_rst", r, 32'h0);
    chk("resp", hresp, 0);
    bus(1, CTRL_OFS, 32'h0f); bus(0, CTRL_OFS, 0); chk("ctrl", r[3:0], 4'hf);
    chk("plug_ie", plug, 1);
    k = 0; while (fcpu !== 1'b1 && k < 40) begin @(posedge clk); k++; end
    k = 0; while (fcpu !== 1'b0 && k < 40) begin @(posedge clk); k++; end
    h = 0; while (fcpu === 1'b0 && h < 40) begin @(posedge clk); h++; end
    l = 0; while (fcpu === 1'b1 && l < 40) begin @(posedge clk); l++; end
    chk("duty", h, l);
    chk("fcpu_runs", h < 40, 1);
    bus(1, CTRL_OFS, 0);
    bus(0, VEC_OFS, 0); chk("vec", r, 32'hfffffffe);
    bus(0, 32'h40, 0); chk("unmapped", r, 0);
    bus(1, OPT_OFS, 1); tick(1); chk("pf4", pf4, 1);
    bus(1, OPT_OFS, 0);
  endtask : t_regs
  // short async pulse of one clock period, starting between edges
  task automatic t_ext;
    #30 pull = 1'b1;
    #100 pull = 1'b0;
    tick(3); t_seq(n);
    chk("stretch", n >= SA + LOW_OUT_CYC - 2, 1);
  endtask : t_ext
  // second underflow in mid-delay restarts it
  task automatic t_wdg;
    wdg <= 1'b1; tick(1); wdg <= 1'b0; tick(2);
    chk("wdg", core_n, 0);
    tick(15); wdg <= 1'b1; tick(1); wdg <= 1'b0; tick(2); t_seq(n);
    chk("restart", n >= SA + LOW_OUT_CYC - 3, 1);
  endtask : t_wdg
  task automatic t_lvd;
    slr <= 1'b1; slf <= 1'b1; tick(GLITCH_CYC - 2); slr <= 1'b0; slf <= 1'b0; tick(6);
    chk("glitch", core_n, 1);
    slr <= 1'b1; slf <= 1'b1; tick(GLITCH_CYC + 4);
    chk("lvd", {core_n, oe_n}, 2'b00);
    slf <= 1'b0; tick(20);
    chk("hyst", {core_n, oe_n}, 2'b00);
    slr <= 1'b0; t_seq(n);
  endtask : t_lvd
  // software resets into usb mode and back
  task automatic t_usb;
    usb <= 1'b1; bus(1, CTRL_OFS, 32'h10); tick(30);
    chk("wait_lock", {core_n, fetch, pll_en}, 3'b001);
    lock <= 1'b1; t_seq(n);
    chk("usb_len", n >= USB && n <= USB + 4, 1);
    chk("usb_mode", {pll_en, psw_oe_n, psw}, 3'b100);
    usb <= 1'b0; lock <= 1'b0; bus(1, CTRL_OFS, 32'h10); tick(2); t_seq(n);
    chk("sa_back", {pll_en, psw_oe_n}, 2'b01);
  endtask : t_usb
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // hang guard
  initial
  begin
    #(6000 * 100);
    mismatches++;
    results;
  end
  initial
  begin
    clk = 0; nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
    hwdata = 0; usb = 0; lock = 0; slr = 0; slf = 0; wdg = 0; pull = 0;
    mismatches = 0; compares = 0;
    tick(4); nrst <= 1'b1; tick(1);
    t_seq(n);
    chk("sa_len", n >= SA + 9 && n <= SA + 16, 1);
    t_regs; t_ext; t_wdg; t_lvd; t_usb;
    results;
  end
endmodule : testbench
`default_nettype wire
